// File: rtl/run_qualifier_params.svh
`ifndef RUN_QUALIFIER_PARAMS_SVH
`define RUN_QUALIFIER_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define RQ_OFF_CTRL      4'h0
`define RQ_OFF_LOCK      4'h4
`define RQ_OFF_STATUS    4'h8
`define RQ_OFF_COM_CMD   4'hC

// ==========================================================================
// Control register fields
`define RQ_CTRL_LSRC_LSB  0
`define RQ_CTRL_FWDEN_BIT 2
`define RQ_CTRL_REVEN_BIT 3
`define RQ_CTRL_ROT_LSB   4
`define RQ_CTRL_EDGE_BIT  6
`define RQ_CTRL_UNITS_BIT 7
`define RQ_CTRL_FKEY_LSB  8
`define RQ_CTRL_NSRC_LSB  12
`define RQ_CTRL_RESET     32'h0000_0156

// ==========================================================================
// Codes and values
`define RQ_LSRC_TERM     2'h1
`define RQ_LSRC_PANEL    2'h2
`define RQ_LSRC_COM      2'h3
`define RQ_NSRC_TERM     2'h0
`define RQ_NSRC_PANEL    2'h1
`define RQ_NSRC_COM      2'h2
`define RQ_ROT_FWD       2'h1
`define RQ_ROT_REV       2'h2
`define RQ_ROT_BOTH      2'h3
`define RQ_FKEY_LOCREM   2'h2
`define RQ_FKEY_COMBINED 2'h3
`define RQ_LOCK_TOGGLE   14'h0123
`define RQ_LOCK_MAX      14'h270F
`define RQ_FREQ_SI       7'h32
`define RQ_FREQ_US       7'h3C
`define RQ_VOLT_SI       10'h190
`define RQ_VOLT_US       10'h1CC

`endif

// File: rtl/run_qualifier_pkg.sv
package run_qualifier_pkg;

  typedef enum logic [1:0] {
    SRC_TERMINAL,
    SRC_PANEL,
    SRC_SERIAL,
    SRC_NONE
  } cmd_source_e;

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_FORWARD,
    RUN_REVERSE
  } run_state_e;

  typedef logic [13:0] lock_code_t;

endpackage

// File: rtl/run_qualifier_ifs.sv
`timescale 1ns/1ns
// ==========================================================================
// Conditioned input group: level plus one-cycle edge pulses.
interface cond_if #(parameter int W = 4);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ==========================================================================
// Lock code entry towards the lock keeper.
interface lock_if;
  logic                          entry_valid;
  run_qualifier_pkg::lock_code_t entry_code;
  run_qualifier_pkg::lock_code_t last_code;
  logic                          locked;
  modport keeper (input entry_valid, input entry_code, output last_code, output locked);
  modport user (output entry_valid, output entry_code, input last_code, input locked);
endinterface

// File: rtl/input_conditioner.sv
`timescale 1ns/1ns
module input_conditioner #(
  parameter int W = 4
) (
  input  wire logic         clk_i,   // System clock.
  input  wire logic         rst_n_i, // Asynchronous reset, active low.
  input  wire logic [W-1:0] pins_i,  // Raw asynchronous pins.
  cond_if.src               cond     // Synchronised level and edges.
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // ==========================================================================
  // Per-pin synchroniser and edge detector.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= pins_i[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
      assign cond.level[g] = sync_reg[g];
      assign cond.rise[g]  = sync_reg[g] & ~prev_reg[g];
      assign cond.fall[g]  = ~sync_reg[g] & prev_reg[g];
    end
  endgenerate

endmodule

// File: rtl/lock_keeper.sv
`timescale 1ns/1ns
`include "run_qualifier_params.svh"
module lock_keeper (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_n_i, // Asynchronous reset, active low.
  lock_if.keeper    lk       // Code entry and lock state.
);

  logic locked_reg;
  run_qualifier_pkg::lock_code_t code_reg;

  // ==========================================================================
  // Entries outside the range are dropped so the stored code stays legal.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg <= 14'h0000;
    end else if (lk.entry_valid && lk.entry_code <= `RQ_LOCK_MAX) begin
      code_reg <= lk.entry_code;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_reg <= 1'b0;
    end else if (lk.entry_valid && lk.entry_code == `RQ_LOCK_TOGGLE) begin
      locked_reg <= ~locked_reg;
    end
  end

  assign lk.last_code = code_reg;
  assign lk.locked    = locked_reg;

endmodule

// File: rtl/run_command_qualifier.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "run_qualifier_params.svh"
module run_command_qualifier (
  input  wire logic        clk_i,               // System clock, 125 MHz.
  input  wire logic        rst_n_i,             // Asynchronous reset, active low.
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_i,       // Byte address.
  input  wire logic        avs_read_i,          // Read request.
  input  wire logic        avs_write_i,         // Write request.
  input  wire logic [3:0]  avs_byteenable_i,    // Write byte lanes.
  input  wire logic [31:0] avs_writedata_i,     // Write data.
  output logic [31:0]      avs_readdata_o,      // Read data.
  output logic             avs_waitrequest_o,   // Stall while high.
  // Terminal digital inputs.
  input  wire logic        run_forward_input_i, // Forward run, active high.
  input  wire logic        run_reverse_input_i, // Reverse run, active high.
  input  wire logic        term_stop_i,         // Stop, active low.
  input  wire logic        term_reset_i,        // Reset, active high.
  // Control panel keys.
  input  wire logic        forward_start_key_i, // Start forward key.
  input  wire logic        reverse_key_i,       // Start reverse key.
  input  wire logic        stop_key_i,          // Stop/reset key stop part.
  input  wire logic        reset_key_i,         // Reset key.
  input  wire logic        function_key_i,      // Function key.
  // Qualified results.
  output logic             run_o,               // Motor run request.
  output logic             reverse_o,           // Direction, high for reverse.
  output logic             reset_cmd_o,         // Fault reset command.
  output logic             local_mode_o,        // Local operation active.
  output logic             locked_o,            // Keyboard locked.
  output logic             units_us_o,          // US units selected.
  output logic [6:0]       nominal_freq_o,      // Default nominal frequency, Hz.
  output logic [9:0]       nominal_volt_o       // Default nominal voltage, V.
);

  // ==========================================================================
  // Local signals.
  logic [31:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic [3:0]  com_cmd_reg;
  logic        local_reg;
  logic        reset_reg;
  logic [6:0]  freq_reg;
  logic [9:0]  volt_reg;
  logic        req;
  logic        wr_take;
  logic [31:0] wmask;
  logic [31:0] ctrl_next;
  logic [31:0] rd_next;
  logic [1:0]  lsrc;
  logic [1:0]  nsrc;
  logic [1:0]  rot;
  logic [1:0]  fkey;
  logic        fwd_key_en;
  logic        rev_key_en;
  logic        edge_mode;
  logic        units_us;
  logic        fwd_ok;
  logic        rev_ok;
  logic        forward_start_key;
  logic        start_rev;
  logic        stop_cmd;
  logic        reset_cmd;
  logic        level_mode_term;
  logic        level_fwd;
  logic        level_rev;

  run_qualifier_pkg::cmd_source_e active_src;
  run_qualifier_pkg::run_state_e  run_state_reg;
  run_qualifier_pkg::run_state_e  run_state_next;

  cond_if #(.W(4)) term_c ();
  cond_if #(.W(5)) panel_c ();
  lock_if          lk ();

  // ==========================================================================
  // Input conditioning and lock keeping.
  input_conditioner #(.W(4)) u_term_cond (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pins_i  ({term_reset_i, term_stop_i, run_reverse_input_i, run_forward_input_i}),
    .cond    (term_c)
  );

  input_conditioner #(.W(5)) u_panel_cond (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pins_i  ({function_key_i, reset_key_i, stop_key_i, reverse_key_i, forward_start_key_i}),
    .cond    (panel_c)
  );

  lock_keeper u_lock (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .lk      (lk)
  );

  // ==========================================================================
  // Avalon-MM slave: every access sees exactly one wait cycle.
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_take           = avs_write_i & ack_reg;
  assign avs_readdata_o    = rdata_reg;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address_i)
      `RQ_OFF_CTRL: begin
        rd_next = ctrl_reg;
      end
      `RQ_OFF_LOCK: begin
        rd_next = {18'h00000, lk.last_code};
      end
      `RQ_OFF_STATUS: begin
        rd_next = {9'h000, freq_reg, 6'h00, volt_reg};
        rd_next[31] = lk.locked;
        rd_next[30] = local_reg;
        rd_next[29] = (run_state_reg != run_qualifier_pkg::RUN_IDLE);
        rd_next[28] = (run_state_reg == run_qualifier_pkg::RUN_REVERSE);
        rd_next[27] = units_us;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data is loaded in the wait cycle so it stands at the accepting edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
      rdata_reg <= rd_next;
    end
  end

  // ==========================================================================
  // Settings register; writes are refused while the keyboard is locked.
  assign ctrl_next = (ctrl_reg & ~wmask) | (avs_writedata_i & wmask);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `RQ_CTRL_RESET;
    end else if (wr_take && avs_address_i == `RQ_OFF_CTRL && !lk.locked) begin
      ctrl_reg <= ctrl_next & 32'h0000_33FF;
    end
  end

  assign lsrc       = ctrl_reg[`RQ_CTRL_LSRC_LSB+1:`RQ_CTRL_LSRC_LSB];
  assign nsrc       = ctrl_reg[`RQ_CTRL_NSRC_LSB+1:`RQ_CTRL_NSRC_LSB];
  assign rot        = ctrl_reg[`RQ_CTRL_ROT_LSB+1:`RQ_CTRL_ROT_LSB];
  assign fkey       = ctrl_reg[`RQ_CTRL_FKEY_LSB+1:`RQ_CTRL_FKEY_LSB];
  assign fwd_key_en = ctrl_reg[`RQ_CTRL_FWDEN_BIT];
  assign rev_key_en = ctrl_reg[`RQ_CTRL_REVEN_BIT];
  assign edge_mode  = ctrl_reg[`RQ_CTRL_EDGE_BIT];
  assign units_us   = ctrl_reg[`RQ_CTRL_UNITS_BIT];

  // Lock code entry is accepted locked or not, when byte lanes 0 and 1 are both enabled.
  assign lk.entry_valid = wr_take && avs_address_i == `RQ_OFF_LOCK && avs_byteenable_i[1:0] == 2'h3;
  assign lk.entry_code  = avs_writedata_i[13:0];

  // Serial commands: bit 0 start forward, 1 start reverse, 2 stop, 3 reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_cmd_reg <= 4'h0;
    end else if (wr_take && avs_address_i == `RQ_OFF_COM_CMD && avs_byteenable_i[0]) begin
      com_cmd_reg <= avs_writedata_i[3:0];
    end else begin
      com_cmd_reg <= 4'h0;
    end
  end

  // ==========================================================================
  // Local/normal operation toggled by the function key.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      local_reg <= 1'b0;
    end else if (panel_c.rise[4] && (fkey == `RQ_FKEY_LOCREM || fkey == `RQ_FKEY_COMBINED)) begin
      local_reg <= ~local_reg;
    end
  end

  // ==========================================================================
  // Command source selection.
  always_comb begin
    active_src = run_qualifier_pkg::SRC_NONE;
    if (local_reg) begin
      case (lsrc)
        `RQ_LSRC_TERM:  active_src = run_qualifier_pkg::SRC_TERMINAL;
        `RQ_LSRC_PANEL: active_src = run_qualifier_pkg::SRC_PANEL;
        `RQ_LSRC_COM:   active_src = run_qualifier_pkg::SRC_SERIAL;
        default:        active_src = run_qualifier_pkg::SRC_NONE;
      endcase
    end else begin
      case (nsrc)
        `RQ_NSRC_TERM:  active_src = run_qualifier_pkg::SRC_TERMINAL;
        `RQ_NSRC_PANEL: active_src = run_qualifier_pkg::SRC_PANEL;
        `RQ_NSRC_COM:   active_src = run_qualifier_pkg::SRC_SERIAL;
        default:        active_src = run_qualifier_pkg::SRC_NONE;
      endcase
    end
  end

  // ==========================================================================
  // Direction permission, applied after every source.
  assign fwd_ok = (rot == `RQ_ROT_FWD) || (rot == `RQ_ROT_BOTH);
  assign rev_ok = (rot == `RQ_ROT_REV) || (rot == `RQ_ROT_BOTH);

  assign level_mode_term = (active_src == run_qualifier_pkg::SRC_TERMINAL) && !edge_mode;
  // Level mode: run holds only while its input is high and stop is high.
  assign level_fwd = term_c.level[0] & fwd_ok & term_c.level[2];
  assign level_rev = term_c.level[1] & rev_ok & term_c.level[2] & ~level_fwd;

  // Panel keys work whether or not the keyboard is locked.
  always_comb begin
    forward_start_key = 1'b0;
    start_rev = 1'b0;
    stop_cmd  = 1'b0;
    reset_cmd = 1'b0;
    case (active_src)
      run_qualifier_pkg::SRC_TERMINAL: begin
        forward_start_key = term_c.rise[0] & fwd_ok;
        start_rev = term_c.rise[1] & rev_ok;
        stop_cmd  = term_c.fall[2];
        reset_cmd = edge_mode ? term_c.rise[3] : term_c.level[3];
      end
      run_qualifier_pkg::SRC_PANEL: begin
        forward_start_key = panel_c.rise[0] & fwd_key_en & fwd_ok;
        start_rev = panel_c.rise[1] & rev_key_en & rev_ok;
        stop_cmd  = panel_c.rise[2];
        reset_cmd = panel_c.rise[3];
      end
      run_qualifier_pkg::SRC_SERIAL: begin
        forward_start_key = com_cmd_reg[0] & fwd_ok;
        start_rev = com_cmd_reg[1] & rev_ok;
        stop_cmd  = com_cmd_reg[2];
        reset_cmd = com_cmd_reg[3];
      end
      default: begin
        forward_start_key = 1'b0;
        start_rev = 1'b0;
        stop_cmd  = 1'b0;
        reset_cmd = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Run state. Outside terminal level mode only a stop or a forbidden direction ends a run, so a stop input must exist.
  always_comb begin
    run_state_next = run_state_reg;
    if (level_mode_term) begin
      if (level_fwd) begin
        run_state_next = run_qualifier_pkg::RUN_FORWARD;
      end else if (level_rev) begin
        run_state_next = run_qualifier_pkg::RUN_REVERSE;
      end else begin
        run_state_next = run_qualifier_pkg::RUN_IDLE;
      end
    end else begin
      case (run_state_reg)
        run_qualifier_pkg::RUN_IDLE: begin
          if (stop_cmd) begin
            run_state_next = run_qualifier_pkg::RUN_IDLE;
          end else if (forward_start_key) begin
            run_state_next = run_qualifier_pkg::RUN_FORWARD;
          end else if (start_rev) begin
            run_state_next = run_qualifier_pkg::RUN_REVERSE;
          end
        end
        run_qualifier_pkg::RUN_FORWARD: begin
          if (stop_cmd || !fwd_ok) begin
            run_state_next = run_qualifier_pkg::RUN_IDLE;
          end
        end
        run_qualifier_pkg::RUN_REVERSE: begin
          if (stop_cmd || !rev_ok) begin
            run_state_next = run_qualifier_pkg::RUN_IDLE;
          end
        end
        default: begin
          run_state_next = run_qualifier_pkg::RUN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_state_reg <= run_qualifier_pkg::RUN_IDLE;
    end else begin
      run_state_reg <= run_state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_reg <= 1'b0;
    end else begin
      reset_reg <= reset_cmd;
    end
  end

  // ==========================================================================
  // Motor defaults follow the unit system.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_reg <= `RQ_FREQ_SI;
      volt_reg <= `RQ_VOLT_SI;
    end else begin
      freq_reg <= units_us ? `RQ_FREQ_US : `RQ_FREQ_SI;
      volt_reg <= units_us ? `RQ_VOLT_US : `RQ_VOLT_SI;
    end
  end

  assign run_o          = (run_state_reg != run_qualifier_pkg::RUN_IDLE);
  assign reverse_o      = (run_state_reg == run_qualifier_pkg::RUN_REVERSE);
  assign reset_cmd_o    = reset_reg;
  assign local_mode_o   = local_reg;
  assign locked_o       = lk.locked;
  assign units_us_o     = units_us;
  assign nominal_freq_o = freq_reg;
  assign nominal_volt_o = volt_reg;

endmodule

// File: tb/run_command_qualifier_monitor.sv
`timescale 1ns/1ns
module run_command_qualifier_monitor (
  input  wire logic        clk_i,             // Clock.
  input  wire logic        rst_n_i,           // Reset, active low.
  input  wire logic [3:0]  avs_address_i,     // Byte address.
  input  wire logic        avs_read_i,        // Read.
  input  wire logic        avs_write_i,       // Write.
  input  wire logic [3:0]  avs_byteenable_i,  // Lanes.
  input  wire logic [31:0] avs_writedata_i,   // Write data.
  input  wire logic        avs_waitrequest_o, // Stall.
  input  wire logic        run_o,             // Running.
  input  wire logic        reverse_o,         // Reverse.
  input  wire logic        locked_o,          // Locked.
  input  wire logic        units_us_o,        // US units.
  input  wire logic [6:0]  nominal_freq_o,    // Frequency.
  input  wire logic [9:0]  nominal_volt_o     // Voltage.
);
  // ==========================================================================
  // Shadow of the rotation limit
  logic       ctrl_acc;
  logic       lock_acc;
  logic       wd_units;
  logic [1:0] rot_reg;
  logic [1:0] rot_d1_reg;
  logic [1:0] rot_d2_reg;
  assign ctrl_acc = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0];
  assign lock_acc = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
  assign wd_units = avs_writedata_i[7];
  // The delayed copies give the design two edges to stop a run that a new limit forbids.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rot_reg    <= 2'h1;
      rot_d1_reg <= 2'h1;
      rot_d2_reg <= 2'h1;
    end else begin
      if (ctrl_acc && !locked_o) begin
        rot_reg <= avs_writedata_i[5:4];
      end
      rot_d1_reg <= rot_reg;
      rot_d2_reg <= rot_d1_reg;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low in the first request cycle");
  one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  freq_units_a: assert property ($stable(units_us_o) |-> nominal_freq_o == (units_us_o ? 7'h3C : 7'h32))
    else $error("nominal frequency does not follow units");
  volt_units_a: assert property ($stable(units_us_o) |-> nominal_volt_o == (units_us_o ? 10'h1CC : 10'h190))
    else $error("nominal voltage does not follow units");
  units_write_a: assert property (ctrl_acc && !locked_o |=> units_us_o == $past(wd_units))
    else $error("units bit not taken from write");
  locked_hold_a: assert property (ctrl_acc && locked_o |=> $stable(units_us_o)[*2])
    else $error("setting changed while locked");
  lock_toggle_a: assert property (lock_acc && avs_writedata_i[13:0] == 14'h0123 && avs_byteenable_i[1:0] == 2'h3
    |=> ##[0:1] $changed(locked_o))
    else $error("lock code did not toggle lock");
  lock_other_a: assert property (lock_acc && avs_writedata_i[13:0] != 14'h0123 |=> $stable(locked_o)[*2])
    else $error("other code changed lock");
  fwd_limit_a: assert property (run_o && !reverse_o && rot_reg == rot_d2_reg |-> rot_reg[0])
    else $error("forward run while forward forbidden");
  rev_limit_a: assert property (run_o && reverse_o && rot_reg == rot_d2_reg |-> rot_reg[1])
    else $error("reverse run while reverse forbidden");

  cover property (run_o && reverse_o);
  cover property ($rose(locked_o));
  cover property ($rose(units_us_o));
endmodule

bind run_command_qualifier run_command_qualifier_monitor i_run_command_qualifier_monitor (.*);

// File: tb/panel_terminal_model.sv
`timescale 1ns/1ns
module panel_terminal_model #(
  parameter int HOLD = 4
) (
  input  wire logic       clk_i,   // Clock.
  input  wire logic [4:0] press_i, // Press requests: forward, reverse, stop, reset, function.
  input  wire logic [3:0] term_i,  // Terminal levels: forward, reverse, stop low, reset.
  output logic [4:0]      keys_o,  // Key contacts.
  output logic [3:0]      pins_o   // Terminal pins.
);
  int unsigned cnt [5] = '{default: 0};
  initial begin
    keys_o = 5'h00;
    pins_o = 4'h4;
  end
  // A press holds the contact for HOLD cycles, like a finger, so one press is one rising edge.
  always @(posedge clk_i) begin
    pins_o <= term_i;
    for (int k = 0; k < 5; k++) begin
      if (press_i[k]) begin
        cnt[k] <= HOLD;
      end else if (cnt[k] != 0) begin
        cnt[k] <= cnt[k] - 1;
      end
      keys_o[k] <= press_i[k] || cnt[k] > 1;
    end
  end
endmodule

// File: tb/run_command_qualifier_tb.sv
`timescale 1ns/1ns
module run_command_qualifier_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        run_forward_input_i, run_reverse_input_i, term_stop_i, term_reset_i;
  logic        forward_start_key_i, reverse_key_i, stop_key_i, reset_key_i, function_key_i;
  logic        run_o, reverse_o, reset_cmd_o, local_mode_o, locked_o, units_us_o;
  logic [6:0]  nominal_freq_o;
  logic [9:0]  nominal_volt_o;
  logic [4:0]  press = 5'h00;
  logic [3:0]  term = 4'h4;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_resets = 0;
  int          r0 = 0;

  always #4 clk_i = ~clk_i;

  // Reset commands outside terminal level mode are short pulses, so they are counted rather than sampled once.
  always @(posedge clk_i) begin
    if (reset_cmd_o === 1'b1) begin
      n_resets <= n_resets + 1;
    end
  end

  panel_terminal_model #(.HOLD(3)) i_panel_terminal_model (
    .clk_i   (clk_i),
    .press_i (press),
    .term_i  (term),
    .keys_o  ({function_key_i, reset_key_i, stop_key_i, reverse_key_i, forward_start_key_i}),
    .pins_o  ({term_reset_i, term_stop_i, run_reverse_input_i, run_forward_input_i})
  );
  run_command_qualifier i_run_command_qualifier (.*);

  // ==========================================================================
  // Tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then lets one edge pass idle.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 50) begin
      n_errors++;
    end
    @(posedge clk_i);
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic prs(input int k);
    press[k] <= 1'b1;
    @(posedge clk_i);
    press <= 5'h00;
  endtask

  task automatic st(input logic [1:0] e);
    repeat (10) @(posedge clk_i);
    chk({30'h0, run_o, reverse_o}, {30'h0, e});
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc(4'h0, 32'h0000_0156);
    rdc(4'h8, 32'h0032_0190);
    rdc(4'h4, 32'h0000_0000);
    $display("test defaults done");
    wrt(4'h0, 32'h0000_0256);
    prs(4);
    st(2'b00);
    chk({31'h0, local_mode_o}, 32'h1);
    prs(0);
    st(2'b10);
    prs(2);
    st(2'b00);
    prs(1);
    st(2'b00);
    wrt(4'h0, 32'h0000_025E);
    prs(1);
    st(2'b00);
    wrt(4'h0, 32'h0000_027E);
    prs(1);
    st(2'b11);
    prs(2);
    st(2'b00);
    wrt(4'h0, 32'h0000_026E);
    prs(0);
    st(2'b00);
    wrt(4'h0, 32'h0000_027A);
    prs(0);
    st(2'b00);
    $display("test panel done");
    wrt(4'h0, 32'h0000_0277);
    prs(0);
    st(2'b00);
    wrt(4'hC, 32'h0000_0001);
    st(2'b10);
    wrt(4'hC, 32'h0000_0004);
    wrt(4'hC, 32'h0000_0002);
    st(2'b11);
    wrt(4'hC, 32'h0000_0004);
    wrt(4'h0, 32'h0000_0257);
    wrt(4'hC, 32'h0000_0002);
    st(2'b00);
    $display("test serial done");
    wrt(4'h0, 32'h0000_0275);
    term <= 4'h5;
    st(2'b10);
    term <= 4'h1;
    st(2'b00);
    term <= 4'h5;
    st(2'b00);
    r0 = n_resets;
    term <= 4'hD;
    st(2'b00);
    chk(n_resets - r0, 32'h1);
    term <= 4'h4;
    wrt(4'h0, 32'h0000_0235);
    term <= 4'h5;
    st(2'b10);
    term <= 4'h4;
    st(2'b00);
    term <= 4'hC;
    st(2'b00);
    chk({31'h0, reset_cmd_o}, 32'h1);
    term <= 4'h4;
    st(2'b00);
    chk({31'h0, reset_cmd_o}, 32'h0);
    $display("test terminal done");
    wrt(4'h0, 32'h0000_02B5);
    st(2'b00);
    chk({25'h0, nominal_freq_o}, 32'h3C);
    chk({22'h0, nominal_volt_o}, 32'h1CC);
    wrt(4'h0, 32'h0000_0276);
    st(2'b00);
    chk({25'h0, nominal_freq_o}, 32'h32);
    $display("test units done");
    wrt(4'h4, 32'h0000_0123);
    st(2'b00);
    chk({31'h0, locked_o}, 32'h1);
    wrt(4'h0, 32'h0000_02B6);
    rdc(4'h0, 32'h0000_0276);
    prs(0);
    st(2'b10);
    prs(2);
    st(2'b00);
    r0 = n_resets;
    prs(3);
    st(2'b00);
    chk(n_resets - r0, 32'h1);
    wrt(4'h4, 32'h0000_2710);
    rdc(4'h4, 32'h0000_0123);
    wrt(4'h4, 32'h0000_0123);
    st(2'b00);
    chk({31'h0, locked_o}, 32'h0);
    $display("test lock done");
    final_report;
  end

  // The tests need well under 2000 cycles; the margin absorbs slow answers.
  initial begin
    repeat (6000) @(posedge clk_i);
    n_errors++;
    final_report;
  end
endmodule
